// ===== src/txctx_dq_status.sv
// Done-queue status filter by reporting mode
`default_nettype none
module txctx_dq_status (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       valid_in,
	input  wire logic       per_buffer_in,
	input  wire logic [2:0] status_in,
	output logic            valid_out,
	output logic [2:0]      status_out
);
	import txctx_pkg::*;

	logic       buf_code;
	logic [2:0] next_status;

	// Per-buffer success codes mean nothing in per-packet mode
	always_comb begin
		buf_code = (status_in != DQ_STATUS_OK) &&
			(status_in <= DQ_STATUS_BUF_LAST);
		next_status = status_in;
		if (buf_code && !per_buffer_in) begin
			next_status = DQ_STATUS_OK; // RULE6
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_out  <= 1'b0;
			status_out <= 3'h0;
		end else begin
			valid_out  <= valid_in;
			status_out <= next_status;
		end
	end
endmodule
`default_nettype wire

// ===== src/txctx_mem.sv
// Dword array holding six context dwords for every channel
`default_nettype none
module txctx_mem (
	input  wire logic    clk_in,
	input  wire logic    rst_in,
	txctx_mem_if.mem     port
);
	import txctx_pkg::*;

	logic [31:0] store [0:CTX_DWORDS-1];

	// Byte lanes let the host touch only the low half of a dword
	always_ff @(posedge clk_in) begin
		if (port.req && port.we) begin
			for (int b = 0; b < 4; b++) begin
				if (port.be[b]) begin
					store[port.addr][b*8 +: 8] <= port.wdata[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			port.rdata <= 32'h0000_0000;
		end else if (port.req && !port.we) begin
			port.rdata <= store[port.addr];
		end
	end
endmodule
`default_nettype wire

// ===== src/txctx_mem_if.sv
// Carrier between the context controller and its dword memory
`default_nettype none
interface txctx_mem_if;
	import txctx_pkg::*;
	logic              req;
	logic              we;
	logic [CTX_AW-1:0] addr;
	logic [3:0]        be;
	logic [31:0]       wdata;
	logic [31:0]       rdata;

	modport ctrl (output req, output we, output addr, output be,
		output wdata, input rdata);
	modport mem (input req, input we, input addr, input be,
		input wdata, output rdata);
endinterface
`default_nettype wire

// ===== src/txctx_pkg.sv
// Constants and types for the transmit DMA channel context store
`default_nettype none
package txctx_pkg;
	localparam int unsigned NUM_CHANNELS  = 40;
	localparam int unsigned DWORDS_PER_CH = 6;
	localparam int unsigned CTX_DWORDS    = 240;
	localparam int unsigned CTX_AW        = 8;

	localparam logic [11:0] ADDR_SELECT = 12'h870;
	localparam logic [11:0] ADDR_DATA   = 12'h874;
	localparam logic [15:0] SELECT_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET   = 16'h0000;

	localparam int unsigned SEL_CH_LSB   = 0;
	localparam int unsigned SEL_WORD_LSB = 8;
	localparam int unsigned SEL_RW_BIT   = 14;
	localparam int unsigned SEL_BUSY_BIT = 15;
	localparam logic [5:0]  LAST_CHANNEL = 6'h27;
	localparam logic [3:0]  WORD_WRITABLE = 4'h2;
	localparam logic [3:0]  WORD_LAST     = 4'hb;

	localparam logic [2:0]  DW_BUF_ADDR  = 3'h0;
	localparam logic [2:0]  DW_CONTROL   = 3'h1;
	localparam int unsigned CTL_ENABLE_BIT  = 0;
	localparam int unsigned CTL_DQ_SEL_BIT  = 1;
	localparam int unsigned CTL_COUNT_LSB   = 3;
	localparam int unsigned CTL_CHAIN_BIT   = 16;
	localparam int unsigned CTL_EOF_BIT     = 17;
	localparam int unsigned CTL_STD_Q_LSB   = 18;
	localparam int unsigned CTL_PRI_Q_LSB   = 20;
	localparam int unsigned CTL_PRI_ACT_BIT = 22;
	// Live bits per dword; unused fields read back as zero
	localparam logic [31:0] DW1_LIVE_MASK = 32'h007f_fffb;
	localparam logic [31:0] DW4_LIVE_MASK = 32'h0000_ffff;
	localparam logic [31:0] ALL_LIVE_MASK = 32'hffff_ffff;

	localparam logic [2:0]  DQ_STATUS_OK = 3'h0;
	localparam logic [2:0]  DQ_STATUS_BUF_LAST = 3'h3;

	typedef enum logic [1:0] {
		QS_NONE,
		QS_NEXT_ONLY,
		QS_PENDING_ONLY,
		QS_BOTH
	} txctx_qstate_t;
endpackage
`default_nettype wire

// ===== src/txctx_ram.sv
// Transmit DMA channel context store with indirect host access
// Functional notes
// RULE1: 240 context dwords, six per channel, forty channels.
// RULE2: Host writes only the low half of dword 1; rest read-only.
// RULE3: Dword 0 holds the current 32-bit data buffer address.
// RULE4: Dword 1 bit 0 enables channel; host and DMA both change it.
// RULE5: Dword 1 bit 1 picks per-packet or per-buffer done reporting.
// RULE6: Per-packet mode reports only 000 as success; per-buffer adds 001-011.
// RULE7: Dword 1 bits 3-15 count bytes in buffer, 0 to 8191.
// RULE8: Dword 1 bits 16,17 copy descriptor chain-valid and end-of-frame.
// RULE9: Dword 1 bits 18-19 mark standard pointer validity.
// RULE10: Dword 1 bits 20-21 mark priority pointer validity, same code.
// RULE11: Dword 1 bit 22 set while a priority packet is worked on.
// RULE12: Unused bits carry no function; they read as zero here.
// RULE13: Dword 2 low half is next descriptor offset of current packet.
// RULE14: Dword 2 high half is start descriptor offset of current packet.
// RULE15: Dword 3 holds next and last pending packet offsets.
// RULE16: Dwords 4 and 5 hold the priority pointer offsets.
// RULE17: Select bits 0-5 name the channel, 00h to 27h.
// RULE18: Select bits 8-11 pick a 16-bit half; only code 0010 writable.
// RULE19: Read bit 1 sets busy, fetches word, then clears busy.
// RULE20: Write bit 0 stores the data register, then clears busy.
// RULE21: Busy bit 15 is read-only, high throughout any access.
// RULE22: Data register is 16 bits, written or returned word.
// RULE23: Select write starts access; other word writes change nothing.
// RULE24: Host waits for busy low before touching data or selecting again.
`default_nettype none
module txctx_ram (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [11:0] reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic [15:0]      reg_rdata_out,
	input  wire logic        dma_req_in,
	input  wire logic        dma_we_in,
	input  wire logic [5:0]  dma_ch_in,
	input  wire logic [2:0]  dma_dword_in,
	input  wire logic [3:0]  dma_be_in,
	input  wire logic [31:0] dma_wdata_in,
	output logic             dma_rvalid_out,
	output logic [31:0]      dma_rdata_out,
	input  wire logic [5:0]  dma_evt_ch_in,
	input  wire logic        dma_error_in,
	input  wire logic        dma_channel_reset_flag_in,
	input  wire logic        dma_dq_valid_in,
	input  wire logic [2:0]  dma_dq_status_in,
	output logic             dma_dq_valid_out,
	output logic [2:0]       dma_dq_status_out,
	output logic [txctx_pkg::NUM_CHANNELS-1:0] channel_enable_out,
	output logic [txctx_pkg::NUM_CHANNELS-1:0] dq_per_buffer_out
);
	import txctx_pkg::*;

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_READ,
		HS_LATCH,
		HS_WRITE
	} txctx_host_state_t;

	txctx_host_state_t host_state;
	txctx_host_state_t next_host_state;

	logic [5:0]  sel_channel;
	logic [3:0]  sel_word;
	logic        sel_read;
	logic [15:0] data_reg;
	logic        indirect_busy;
	logic        start_access;
	logic        host_slot;
	logic        host_wr_ok;
	logic        sel_valid;
	logic [CTX_AW-1:0] host_index;
	logic [CTX_AW-1:0] dma_index;
	logic        dma_rd_q;
	logic [5:0]  dma_ch_q;
	logic [2:0]  dma_dw_q;
	logic        dma_ok;
	logic        dma_ok_q;
	logic        evt_ok;
	logic        evt_per_buffer;
	logic        data_load;
	logic        host_wr_done;
	logic [15:0] select_view;
	logic [31:0] host_dword;
	logic [15:0] host_half;

	txctx_mem_if mem_bus ();

	txctx_mem u_mem (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.port   (mem_bus.mem)
	);

	// Channel times six from shifts, keeping a multiplier off the path
	function automatic logic [CTX_AW-1:0] ctx_index(
		input logic [5:0] ch,
		input logic [2:0] dw
	);
		ctx_index = (CTX_AW'(ch) << 2) + (CTX_AW'(ch) << 1) + CTX_AW'(dw);
	endfunction

	// Live bits of a dword; enable and mode bits come from flops
	function automatic logic [31:0] ctx_view(
		input logic [31:0] raw,
		input logic [2:0]  dw,
		input logic        en,
		input logic        dqs
	);
		logic [31:0] v;
		v = raw;
		if (dw == DW_CONTROL) begin
			v = raw & DW1_LIVE_MASK; // RULE12
			v[CTL_ENABLE_BIT] = en;
			v[CTL_DQ_SEL_BIT] = dqs;
		end else if (dw == 3'h4) begin
			v = raw & DW4_LIVE_MASK; // RULE12
		end else begin
			v = raw & ALL_LIVE_MASK;
		end
		ctx_view = v;
	endfunction

	assign indirect_busy = (host_state != HS_IDLE); // RULE21
	assign start_access  = reg_wr_in && (reg_addr_in == ADDR_SELECT) &&
		!indirect_busy; // RULE23
	assign sel_valid  = (sel_channel <= LAST_CHANNEL) &&
		(sel_word <= WORD_LAST); // RULE17 RULE18
	assign host_wr_ok = (sel_channel <= LAST_CHANNEL) &&
		(sel_word == WORD_WRITABLE); // RULE2 RULE18 RULE23
	assign host_index = ctx_index(sel_channel, sel_word[3:1]);
	assign dma_index  = ctx_index(dma_ch_in, dma_dword_in);
	// The DMA owns the memory whenever it asks; the host access waits
	assign host_slot  = !dma_req_in;

	// Out-of-range DMA targets would alias another channel's dwords
	assign dma_ok = (dma_ch_in <= LAST_CHANNEL) &&
		(dma_dword_in < 3'(DWORDS_PER_CH)); // RULE1
	assign host_wr_done = (host_state == HS_WRITE) && host_slot;
	assign data_load = reg_wr_in && (reg_addr_in == ADDR_DATA) &&
		!indirect_busy;
	assign evt_ok = (dma_evt_ch_in <= LAST_CHANNEL);

	always_comb begin
		mem_bus.req   = 1'b0;
		mem_bus.we    = 1'b0;
		mem_bus.addr  = host_index;
		mem_bus.be    = 4'h0;
		mem_bus.wdata = {16'h0000, data_reg};
		if (dma_req_in) begin
			mem_bus.req   = dma_ok; // RULE1
			mem_bus.we    = dma_we_in;
			mem_bus.addr  = dma_index;
			mem_bus.be    = dma_be_in;
			mem_bus.wdata = dma_wdata_in; // RULE3 RULE7 RULE8 RULE9
		end else if (host_state == HS_READ) begin
			mem_bus.req = 1'b1;
		end else if (host_state == HS_WRITE && host_wr_ok) begin
			mem_bus.req = 1'b1;
			mem_bus.we  = 1'b1;
			// Upper lanes stay shut so DMA-owned bits are never touched
			mem_bus.be  = 4'h3; // RULE2
		end
	end

	// Reads need a latch cycle: memory data lands one edge after request
	always_comb begin
		next_host_state = host_state;
		case (host_state)
			HS_IDLE: begin
				if (start_access) begin
					next_host_state = reg_wdata_in[SEL_RW_BIT] ?
						HS_READ : HS_WRITE;
				end
			end
			HS_READ: begin
				if (host_slot) begin
					next_host_state = HS_LATCH;
				end
			end
			HS_LATCH: begin
				next_host_state = HS_IDLE;
			end
			HS_WRITE: begin
				if (host_slot) begin
					next_host_state = HS_IDLE;
				end
			end
			default: begin
				next_host_state = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			host_state <= HS_IDLE;
		end else begin
			host_state <= next_host_state; // RULE19 RULE20
		end
	end

	// Select fields freeze while busy so the access target stays put
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_channel <= SELECT_RESET[SEL_CH_LSB +: 6];
			sel_word    <= SELECT_RESET[SEL_WORD_LSB +: 4];
			sel_read    <= SELECT_RESET[SEL_RW_BIT];
		end else if (start_access) begin
			sel_channel <= reg_wdata_in[SEL_CH_LSB +: 6]; // RULE17
			sel_word    <= reg_wdata_in[SEL_WORD_LSB +: 4]; // RULE18
			sel_read    <= reg_wdata_in[SEL_RW_BIT];
		end
	end

	always_comb begin
		host_dword = ctx_view(mem_bus.rdata, sel_word[3:1],
			channel_enable_out[sel_channel],
			dq_per_buffer_out[sel_channel]);
		host_half = sel_word[0] ? host_dword[31:16] : host_dword[15:0];
		if (!sel_valid) begin
			host_half = 16'h0000;
		end
	end

	// Reserved select bits read back as zero
	always_comb begin
		select_view                    = 16'h0000;
		select_view[SEL_CH_LSB +: 6]   = sel_channel; // RULE17
		select_view[SEL_WORD_LSB +: 4] = sel_word; // RULE18
		select_view[SEL_RW_BIT]        = sel_read;
		select_view[SEL_BUSY_BIT]      = indirect_busy; // RULE21
	end

	// Host loads of the data register are ignored during an access
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_reg <= DATA_RESET;
		end else if (host_state == HS_LATCH) begin
			data_reg <= host_half; // RULE19 RULE22
		end else if (data_load) begin
			data_reg <= reg_wdata_in; // RULE22
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_SELECT: begin
					reg_rdata_out <= select_view; // RULE21
				end
				ADDR_DATA: begin
					reg_rdata_out <= data_reg;
				end
				default: begin
					reg_rdata_out <= 16'h0000;
				end
			endcase
		end
	end

	// Enable and reporting mode per channel; DMA events beat host writes
	generate
		for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
			logic host_hit;
			logic evt_hit;
			assign host_hit = host_wr_done && host_wr_ok &&
				(sel_channel == 6'(c));
			assign evt_hit = (dma_evt_ch_in == 6'(c));

			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					channel_enable_out[c] <= 1'b0;
				end else if (evt_hit && dma_channel_reset_flag_in) begin
					channel_enable_out[c] <= 1'b1; // RULE4
				end else if (evt_hit && dma_error_in) begin
					channel_enable_out[c] <= 1'b0; // RULE4
				end else if (host_hit) begin
					channel_enable_out[c] <= data_reg[CTL_ENABLE_BIT]; // RULE4
				end
			end

			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					dq_per_buffer_out[c] <= 1'b0;
				end else if (host_hit) begin
					dq_per_buffer_out[c] <= data_reg[CTL_DQ_SEL_BIT]; // RULE5
				end
			end
		end
	endgenerate

	// Read qualifiers ride alongside the memory's own read register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dma_rd_q <= 1'b0;
			dma_ch_q <= 6'h00;
			dma_dw_q <= 3'h0;
			dma_ok_q <= 1'b0;
		end else begin
			dma_rd_q <= dma_req_in && !dma_we_in;
			dma_ch_q <= dma_ch_in;
			dma_dw_q <= dma_dword_in;
			dma_ok_q <= dma_ok;
		end
	end

	// DMA sees the same live view as the host, one cycle after asking
	assign dma_rvalid_out = dma_rd_q;
	always_comb begin
		dma_rdata_out = ctx_view(mem_bus.rdata, dma_dw_q, // RULE13 RULE14
			channel_enable_out[dma_ch_q], // RULE10 RULE11
			dq_per_buffer_out[dma_ch_q]); // RULE15 RULE16
		if (!dma_ok_q) begin
			dma_rdata_out = 32'h0000_0000;
		end
	end

	// Unknown channels count as per-packet, not a read past the flops
	always_comb begin
		evt_per_buffer = 1'b0;
		if (evt_ok) begin
			evt_per_buffer = dq_per_buffer_out[dma_evt_ch_in];
		end
	end

	txctx_dq_status u_dq_status (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.valid_in      (dma_dq_valid_in),
		.per_buffer_in (evt_per_buffer),
		.status_in     (dma_dq_status_in),
		.valid_out     (dma_dq_valid_out),
		.status_out    (dma_dq_status_out)
	); // RULE6
endmodule
`default_nettype wire

// ===== tb/txctx_ram_bench.sv
// Self-checking bench for the transmit context store
`default_nettype none
module txctx_ram_bench import txctx_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in = 0, rst_in = 1, wr = 0, rd = 0, dreq = 0, dwe = 0;
	logic        err = 0, crst = 0, dqv = 0, chk_rd = 0, rd_p = 0;
	logic        rvalid, dqv_o, en_m = 0, pb_m = 0;
	logic [11:0] addr = 0;
	logic [15:0] wd = 0, rdata;
	logic [5:0]  dch = 0, ech = 0;
	logic [2:0]  ddw = 0, dqs_in = 0, dq_st;
	logic [31:0] dwd = 0, drd, q[$], mem[6];
	logic [2:0]  dq_q[$];
	logic [NUM_CHANNELS-1:0] en_o, pb_o;
	int          err_count = 0, n_tests = 0;

	txctx_ram dut_u (.clk_in, .rst_in, .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata),
		.dma_req_in(dreq), .dma_we_in(dwe), .dma_ch_in(dch),
		.dma_dword_in(ddw), .dma_be_in(4'hf), .dma_wdata_in(dwd),
		.dma_rvalid_out(rvalid), .dma_rdata_out(drd),
		.dma_evt_ch_in(ech), .dma_error_in(err), .dma_channel_reset_flag_in(crst),
		.dma_dq_valid_in(dqv), .dma_dq_status_in(dqs_in),
		.dma_dq_valid_out(dqv_o), .dma_dq_status_out(dq_st),
		.channel_enable_out(en_o), .dq_per_buffer_out(pb_o));

	initial forever #2.5 clk_in = ~clk_in;

	task automatic final_report();
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Strobes stay up until the next transfer or a DMA sweep lowers them
	task automatic bus(logic w, logic [11:0] a, logic [15:0] d,
		logic c = 1'b0);
		wr = w;
		rd = !w;
		chk_rd = c;
		addr = a;
		wd = d;
		@(posedge clk_in);
		#1;
	endtask

	task automatic rr(logic [11:0] a, logic [15:0] e);
		q.push_back({16'h0000, e});
		bus(0, a, 16'h0000, 1);
	endtask

	// Every access polls busy; it must be seen high first
	task automatic ind(logic rw, logic [3:0] w, logic [5:0] c);
		bus(1, ADDR_SELECT, {1'b0, rw, 2'b00, w, 2'b00, c});
		bus(0, ADDR_SELECT, 16'h0000);
		chk(rdata[15], 1);
		for (int n = 0; n < 8 && rdata[15] !== 1'b0; n++)
			bus(0, ADDR_SELECT, 16'h0000);
		chk(rdata[15], 0);
	endtask

	// Stored dword as read back: flags overlaid, unused bits zero
	function automatic logic [31:0] xp(int k);
		logic [31:0] v;
		v = mem[k];
		if (k == 1)
			v = v & DW1_LIVE_MASK & 32'hffff_fffc | {30'h0, pb_m, en_m};
		if (k == 4)
			v = v & DW4_LIVE_MASK;
		return v;
	endfunction

	task automatic rdw(int w);
		logic [31:0] e;
		ind(1, 4'(w), LAST_CHANNEL);
		e = xp(w / 2);
		rr(ADDR_DATA, w[0] ? e[31:16] : e[15:0]);
	endtask

	task automatic dsweep(logic w);
		wr = 0;
		rd = 0;
		chk_rd = 0;
		for (int k = 0; k < 6; k++) begin
			if (!w)
				q.push_back(xp(k));
			dreq = 1;
			dwe = w;
			dch = LAST_CHANNEL;
			ddw = 3'(k);
			dwd = mem[k];
			@(posedge clk_in);
			#1;
		end
		dreq = 0;
		@(posedge clk_in);
		#1;
	endtask

	always @(posedge clk_in) rd_p <= rd && chk_rd;
	always @(negedge clk_in) begin
		if (rd_p)
			chk(rdata, q.pop_front());
		if (rvalid)
			chk(drd, q.pop_front());
		if (dqv_o)
			chk(dq_st, dq_q.pop_front());
	end

	initial begin
		#20000;
		err_count++;
		final_report();
	end

	initial begin
		logic [15:0] wv;
		void'($urandom(82166));
		repeat (3) @(posedge clk_in);
		#1;
		rst_in = 0;
		rr(ADDR_SELECT, SELECT_RESET);
		rr(ADDR_DATA, DATA_RESET);
		foreach (mem[k])
			mem[k] = $urandom;
		dsweep(1);
		dsweep(0);
		for (int w = 0; w < 12; w++)
			rdw(w);
		wv = 16'($urandom) | 16'h0003;
		bus(1, ADDR_DATA, wv);
		ind(0, WORD_WRITABLE, LAST_CHANNEL);
		mem[1][15:0] = wv;
		en_m = 1;
		pb_m = 1;
		chk(en_o[LAST_CHANNEL], 1);
		chk(pb_o[LAST_CHANNEL], 1);
		rdw(2);
		for (int w = 0; w < 12; w += 3) begin
			bus(1, ADDR_DATA, 16'($urandom));
			ind(0, 4'(w), LAST_CHANNEL);
			rdw(w);
		end
		dsweep(0);
		ech = LAST_CHANNEL;
		err = 1;
		@(posedge clk_in);
		#1;
		err = 0;
		chk(en_o[ech], 0);
		@(posedge clk_in);
		#1;
		{err, crst} = 2'b11;
		@(posedge clk_in);
		#1;
		{err, crst} = 2'b00;
		chk(en_o[ech], 1);
		for (int i = 0; i < 16; i++) begin
			ech = i[3] ? 6'h00 : LAST_CHANNEL;
			dqs_in = 3'(i);
			dq_q.push_back(!i[3] || i[2:0] > 3 ? 3'(i) : 3'h0);
			dqv = 1;
			@(posedge clk_in);
			#1;
		end
		dqv = 0;
		repeat (3) @(posedge clk_in);
		chk(q.size() + dq_q.size(), 0);
		final_report();
	end
endmodule
`default_nettype wire

// ===== tb/txctx_ram_sva.sv
// Port checker for the transmit context store
`default_nettype none
module txctx_ram_sva import txctx_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        dma_req_in,
	input wire logic        dma_we_in,
	input wire logic [2:0]  dma_dword_in,
	input wire logic        dma_rvalid_out,
	input wire logic [31:0] dma_rdata_out,
	input wire logic [5:0]  dma_evt_ch_in,
	input wire logic        dma_error_in,
	input wire logic        dma_channel_reset_flag_in,
	input wire logic        dma_dq_valid_in,
	input wire logic [2:0]  dma_dq_status_in,
	input wire logic        dma_dq_valid_out,
	input wire logic [2:0]  dma_dq_status_out,
	input wire logic [txctx_pkg::NUM_CHANNELS-1:0] channel_enable_out,
	input wire logic [txctx_pkg::NUM_CHANNELS-1:0] dq_per_buffer_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire logic rd_req = dma_req_in && !dma_we_in;
	wire logic ev_ok  = dma_evt_ch_in <= LAST_CHANNEL;

	property p_rvalid; rd_req |=> dma_rvalid_out; endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read valid missing");
	property p_no_rvalid; !rd_req |=> !dma_rvalid_out; endproperty
	a_no_rvalid: assert property (p_no_rvalid)
		else $error("spurious read valid");
	property p_dq_filter;
		dma_dq_valid_in && ev_ok |=> dma_dq_valid_out &&
		dma_dq_status_out == (($past(dq_per_buffer_out[dma_evt_ch_in])
		|| $past(dma_dq_status_in) > 3'h3) ? $past(dma_dq_status_in) : 3'h0);
	endproperty
	a_dq_filter: assert property (p_dq_filter)
		else $error("done status wrong");
	property p_dq_idle; !dma_dq_valid_in |=> !dma_dq_valid_out; endproperty
	a_dq_idle: assert property (p_dq_idle)
		else $error("spurious done status");
	property p_err;
		dma_error_in && !dma_channel_reset_flag_in && ev_ok
		|=> !channel_enable_out[$past(dma_evt_ch_in)];
	endproperty
	a_err: assert property (p_err)
		else $error("error did not disable");
	property p_channel_reset_flag;
		dma_channel_reset_flag_in && ev_ok |=> channel_enable_out[$past(dma_evt_ch_in)];
	endproperty
	a_channel_reset_flag: assert property (p_channel_reset_flag)
		else $error("reset flag did not enable");
	property p_dqs_one;
		$changed(dq_per_buffer_out)
		|-> $onehot(dq_per_buffer_out ^ $past(dq_per_buffer_out));
	endproperty
	a_dqs_one: assert property (p_dqs_one)
		else $error("mode changed on many channels");
	property p_unused;
		rd_req && dma_dword_in == DW_CONTROL
		|=> (dma_rdata_out & ~DW1_LIVE_MASK) == 32'h0000_0000;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused control bits set");
	property p_unused4;
		rd_req && dma_dword_in == 3'h4
		|=> dma_rdata_out[31:16] == 16'h0000;
	endproperty
	a_unused4: assert property (p_unused4)
		else $error("unused priority bits set");
	property p_rd_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved");

	c_b2b: cover property (rd_req ##1 rd_req);
	c_both: cover property (dma_error_in && dma_channel_reset_flag_in);
	c_buf: cover property (dma_dq_valid_in && dma_dq_status_in == 3'h3);
endmodule
bind txctx_ram txctx_ram_sva chk_u (.clk_in, .rst_in, .reg_rd_in,
	.reg_rdata_out, .dma_req_in, .dma_we_in, .dma_dword_in,
	.dma_rvalid_out, .dma_rdata_out, .dma_evt_ch_in, .dma_error_in,
	.dma_channel_reset_flag_in, .dma_dq_valid_in, .dma_dq_status_in,
	.dma_dq_valid_out, .dma_dq_status_out, .channel_enable_out,
	.dq_per_buffer_out);
`default_nettype wire
